/* File: lpmc_consts.svh */
`ifndef LPMC_CONSTS_SVH
`define LPMC_CONSTS_SVH

// Register byte offsets
`define LPMC_OFS_STBY_CTRL 8'h00
`define LPMC_OFS_MSTOP_A 8'h04
`define LPMC_OFS_MSTOP_B 8'h08
`define LPMC_OFS_MSTOP_C 8'h0C
`define LPMC_OFS_MSTOP_D 8'h10
`define LPMC_OFS_OP_POWER 8'h14
`define LPMC_OFS_RET_CLK 8'h18
`define LPMC_OFS_SNOOZE 8'h1C
`define LPMC_OFS_SW_RESET 8'h20
`define LPMC_OFS_PROTECT 8'h24
`define LPMC_OFS_MODE_STAT 8'h28

// Field positions
`define LPMC_BIT_STANDBY_SEL 0
`define LPMC_BIT_DTC_STOP 28
`define LPMC_BIT_MTU_STOP 9
`define LPMC_BIT_CAN_STOP 0
`define LPMC_BIT_ELC_STOP 8
`define LPMC_BIT_CMPB_STOP 10
`define LPMC_BIT_RAM_STOP 0
`define LPMC_BIT_DEEP_SLEEP_EN 31
`define LPMC_BIT_RET_CLK_EN 7
`define LPMC_BIT_SNOOZE_EN 7
`define LPMC_PROT_CLOCK_GEN 0
`define LPMC_PROT_LOW_POWER 1
`define LPMC_PROT_LP_TIMER 2
`define LPMC_PROT_VOLT_DET 3

// Reset values
`define LPMC_RST_STBY_CTRL 32'h0000_0000
`define LPMC_RST_MSTOP_A 32'hFFFF_FFFF
`define LPMC_RST_MSTOP_B 32'hFFFF_FFFF
`define LPMC_RST_MSTOP_C 32'h7FFF_FFFE
`define LPMC_RST_MSTOP_D 32'hFFFF_FFFF
`define LPMC_RST_OP_POWER 8'h00
`define LPMC_RST_RET_CLK 8'h00
`define LPMC_RST_SNOOZE 8'h00
`define LPMC_RST_PROTECT 4'h0

// Keys and codes
`define LPMC_PROTECT_KEY 8'hA5
`define LPMC_SW_RESET_KEY 16'hA501
`define LPMC_CLK_LOW_SPEED 3'h0
`define LPMC_CLK_HIGH_SPEED 3'h1
`define LPMC_CLK_MAIN 3'h2

`endif

/* File: lpmc_pkg.sv */
package lpmc_pkg;

    typedef enum logic [2:0] {
        LPMC_RUN,
        LPMC_SLEEP,
        LPMC_DEEP_SLEEP,
        LPMC_SW_STANDBY,
        LPMC_SNOOZE
    } lpmc_mode_type;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } lpmc_apb_req_type;

    typedef struct packed {
        logic cpu_run;
        logic flash_run;
        logic ram_run;
        logic dtc_run;
        logic periph_run;
        logic main_osc_run;
        logic high_speed_osc_run;
        logic pll_run;
    } lpmc_domain_type;

    typedef struct packed {
        logic mtu_clk_en;
        logic can_clk_en;
        logic elc_clk_en;
        logic cmpb_clk_en;
    } lpmc_unit_clk_type;

endpackage

/* File: lpmc_ctrl.sv */
// The APB register port and the placing of the registers are this design's own decisions.
`include "lpmc_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module lpmc_ctrl #(
    parameter int RAM_TOP = 32'h0000_FFFF
) (
    // Clock, reset, enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    // APB slave
    input wire lpmc_pkg::lpmc_apb_req_type apb_req,
    output logic pready,
    output logic pslverr,
    output logic [31:0] prdata,
    // CPU and wake-up events
    input wire logic wait_exec,
    input wire logic wake_irq,
    input wire logic snooze_request,
    input wire logic snooze_done,
    // Domain and unit controls
    output lpmc_pkg::lpmc_domain_type domain_run,
    output lpmc_pkg::lpmc_unit_clk_type unit_clk,
    output logic [31:0] module_stop_a,
    output logic [31:0] module_stop_b,
    output logic [31:0] module_stop_c,
    output logic [31:0] module_stop_d,
    output logic units_retained,
    output logic units_power_off,
    output logic [7:0] operating_power,
    // Clock return and reset
    output logic [2:0] return_clk_sel,
    output logic return_clk_switch,
    output logic sw_reset_req,
    // Write permission for outside register groups
    output logic clock_gen_wr_ok,
    output logic lp_timer_wr_ok,
    output logic volt_detect_wr_ok
);

    // The RAM stop bit covers one fixed region; a larger RAM
    // would need a second stop bit, so other sizes are refused
    initial begin
        if (RAM_TOP != 32'h0000_FFFF) begin
            $error("lpmc_ctrl: only a 64 KB RAM region is supported");
        end
    end

    lpmc_pkg::lpmc_mode_type mode_q;
    lpmc_pkg::lpmc_mode_type mode_d;
    logic standby_select_q;
    logic [31:0] mstop_a_q;
    logic [31:0] mstop_b_q;
    logic [31:0] mstop_c_q;
    logic [31:0] mstop_d_q;
    logic [7:0] op_power_q;
    logic [2:0] ret_sel_q;
    logic ret_en_q;
    logic [7:0] snooze_ctrl_q;
    logic [3:0] protect_q;
    logic ret_switch_q;
    logic sw_reset_q;
    logic [31:0] rdata_q;
    logic err_q;
    logic access;
    logic wr;
    logic low_power_ok;
    logic ret_code_ok;
    logic [31:0] wdata;
    logic [7:0] addr;

    // Known-register decode, used only by the error path; reads decode separately
    function automatic logic lpmc_mapped(input logic [7:0] a);
        case (a)
            `LPMC_OFS_STBY_CTRL, `LPMC_OFS_MSTOP_A, `LPMC_OFS_MSTOP_B,
            `LPMC_OFS_MSTOP_C, `LPMC_OFS_MSTOP_D, `LPMC_OFS_OP_POWER,
            `LPMC_OFS_RET_CLK, `LPMC_OFS_SNOOZE, `LPMC_OFS_SW_RESET,
            `LPMC_OFS_PROTECT, `LPMC_OFS_MODE_STAT: lpmc_mapped = 1'b1;
            default: lpmc_mapped = 1'b0;
        endcase
    endfunction

    function automatic logic lpmc_is_sleeping(input lpmc_pkg::lpmc_mode_type m);
        lpmc_is_sleeping = (m == lpmc_pkg::LPMC_SLEEP) || (m == lpmc_pkg::LPMC_DEEP_SLEEP);
    endfunction

    assign addr = apb_req.paddr;
    assign wdata = apb_req.pwdata;
    assign access = apb_req.psel && apb_req.penable && clk_en;
    // With clk_en low the access is invisible: no write lands and
    // no wait state is raised, so software must not use the bus then
    assign wr = access && apb_req.pwrite;
    assign low_power_ok = protect_q[`LPMC_PROT_LOW_POWER];
    // Prohibited codes refused only when the written enable bit is set
    assign ret_code_ok = !wdata[`LPMC_BIT_RET_CLK_EN] || (wdata[2:0] == `LPMC_CLK_LOW_SPEED)
        || (wdata[2:0] == `LPMC_CLK_HIGH_SPEED) || (wdata[2:0] == `LPMC_CLK_MAIN);

    // Zero-wait slave: every access completes in its first access cycle
    assign pready = 1'b1;
    assign pslverr = err_q;
    assign prdata = rdata_q;

    // Key in bits 15:8 guards against a stray write
    // clearing the protect bits; a keyless write is dropped
    // whole so the old pattern survives
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            protect_q <= `LPMC_RST_PROTECT;
        end else if (wr && addr == `LPMC_OFS_PROTECT && wdata[15:8] == `LPMC_PROTECT_KEY) begin
            protect_q <= wdata[3:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            standby_select_q <= 1'b0;
            op_power_q <= `LPMC_RST_OP_POWER;
            snooze_ctrl_q <= `LPMC_RST_SNOOZE;
        end else if (wr && low_power_ok) begin
            case (addr)
                `LPMC_OFS_STBY_CTRL: standby_select_q <= wdata[`LPMC_BIT_STANDBY_SEL];
                `LPMC_OFS_OP_POWER: op_power_q <= wdata[7:0];
                `LPMC_OFS_SNOOZE: snooze_ctrl_q <= wdata[7:0];
                default: begin
                end
            endcase
        end
    end

    // Module stop registers: 1 stops, 0 releases
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mstop_a_q <= `LPMC_RST_MSTOP_A;
            mstop_b_q <= `LPMC_RST_MSTOP_B;
            mstop_c_q <= `LPMC_RST_MSTOP_C;
            mstop_d_q <= `LPMC_RST_MSTOP_D;
        end else if (wr && low_power_ok) begin
            case (addr)
                `LPMC_OFS_MSTOP_A: mstop_a_q <= wdata;
                `LPMC_OFS_MSTOP_B: mstop_b_q <= wdata;
                `LPMC_OFS_MSTOP_C: mstop_c_q <= wdata;
                `LPMC_OFS_MSTOP_D: mstop_d_q <= wdata;
                default: begin
                end
            endcase
        end
    end

    // Return-clock register; is software's duty, enforced by the gate
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ret_sel_q <= `LPMC_CLK_LOW_SPEED;
            ret_en_q <= 1'b0;
        end else if (wr && low_power_ok && addr == `LPMC_OFS_RET_CLK && ret_code_ok) begin
            ret_sel_q <= wdata[2:0];
            ret_en_q <= wdata[`LPMC_BIT_RET_CLK_EN];
        end
    end

    // Keyed one-cycle request; a wrong key leaves reset untouched
    // so a runaway program cannot reset the part by accident
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sw_reset_q <= 1'b0;
        end else if (clk_en) begin
            sw_reset_q <= wr && low_power_ok && addr == `LPMC_OFS_SW_RESET
                && wdata[15:0] == `LPMC_SW_RESET_KEY;
        end
    end

    // Read data and error answer, registered for the access cycle edge
    // Decoding at setup keeps prdata a flop output while costing
    // no bus time, since the access phase follows anyway
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_q <= 32'h0000_0000;
            err_q <= 1'b0;
        end else if (clk_en) begin
            err_q <= 1'b0;
            if (apb_req.psel && !apb_req.penable) begin
                err_q <= !lpmc_mapped(addr);
                rdata_q <= 32'h0000_0000;
                if (!apb_req.pwrite) begin
                    case (addr)
                        `LPMC_OFS_STBY_CTRL: rdata_q <= {31'h0000_0000, standby_select_q};
                        `LPMC_OFS_MSTOP_A: rdata_q <= mstop_a_q;
                        `LPMC_OFS_MSTOP_B: rdata_q <= mstop_b_q;
                        `LPMC_OFS_MSTOP_C: rdata_q <= mstop_c_q;
                        `LPMC_OFS_MSTOP_D: rdata_q <= mstop_d_q;
                        `LPMC_OFS_OP_POWER: rdata_q <= {24'h00_0000, op_power_q};
                        `LPMC_OFS_RET_CLK: rdata_q <= {24'h00_0000, ret_en_q, 4'h0, ret_sel_q};
                        `LPMC_OFS_SNOOZE: rdata_q <= {24'h00_0000, snooze_ctrl_q};
                        `LPMC_OFS_PROTECT: rdata_q <= {28'h000_0000, protect_q};
                        `LPMC_OFS_MODE_STAT: rdata_q <= {29'h0000_0000, mode_q};
                        default: rdata_q <= 32'h0000_0000;
                    endcase
                end
            end
        end
    end

    // Mode sequencer
    always_comb begin
        mode_d = mode_q;
        case (mode_q)
            lpmc_pkg::LPMC_RUN: begin
                // Wait is honoured only from run; elsewhere it is dropped
                if (wait_exec) begin
                    if (standby_select_q) begin
                        mode_d = lpmc_pkg::LPMC_SW_STANDBY;
                    end else if (mstop_c_q[`LPMC_BIT_DEEP_SLEEP_EN]) begin
                        mode_d = lpmc_pkg::LPMC_DEEP_SLEEP;
                    end else begin
                        mode_d = lpmc_pkg::LPMC_SLEEP;
                    end
                end
            end
            lpmc_pkg::LPMC_SLEEP, lpmc_pkg::LPMC_DEEP_SLEEP: begin
                // Only an interrupt ends either sleep
                if (wake_irq) begin
                    mode_d = lpmc_pkg::LPMC_RUN;
                end
            end
            lpmc_pkg::LPMC_SW_STANDBY: begin
                // Interrupt has priority over a simultaneous snooze condition
                if (wake_irq) begin
                    mode_d = lpmc_pkg::LPMC_RUN;
                end else if (snooze_request && snooze_ctrl_q[`LPMC_BIT_SNOOZE_EN]) begin
                    mode_d = lpmc_pkg::LPMC_SNOOZE;
                end
            end
            lpmc_pkg::LPMC_SNOOZE: begin
                // Interrupt wins over completion in the same cycle
                if (wake_irq) begin
                    mode_d = lpmc_pkg::LPMC_RUN;
                end else if (snooze_done) begin
                    mode_d = lpmc_pkg::LPMC_SW_STANDBY;
                end
            end
            // Unused encodings recover to run rather than lock up
            default: mode_d = lpmc_pkg::LPMC_RUN;
        endcase
    end

    // Mode register freezes with clk_en, so events during a
    // frozen cycle are lost; callers must hold them if needed
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_q <= lpmc_pkg::LPMC_RUN;
        end else if (clk_en) begin
            mode_q <= mode_d;
        end
    end

    // Switch to the selected oscillator on return from a sleep mode
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ret_switch_q <= 1'b0;
        end else if (clk_en) begin
            ret_switch_q <= ret_en_q && lpmc_is_sleeping(mode_q) && mode_d == lpmc_pkg::LPMC_RUN;
        end
    end

    // Domain gating per mode
    // Standby stops the oscillators and PLL as well; a slow oscillator
    // kept alive for wake-up logic is outside this block
    always_comb begin
        domain_run = '1;
        case (mode_q)
            lpmc_pkg::LPMC_RUN: begin
            end
            lpmc_pkg::LPMC_SLEEP: begin
                domain_run.cpu_run = 1'b0;
            end
            lpmc_pkg::LPMC_DEEP_SLEEP: begin
                domain_run.cpu_run = 1'b0;
                domain_run.ram_run = 1'b0;
                domain_run.dtc_run = 1'b0;
                domain_run.flash_run = 1'b0;
            end
            lpmc_pkg::LPMC_SW_STANDBY: begin
                domain_run = '0;
            end
            lpmc_pkg::LPMC_SNOOZE: begin
                domain_run.cpu_run = 1'b0;
                domain_run.flash_run = 1'b0;
            end
            default: domain_run = '1;
        endcase
        // Optional units still obey their own stop bits
        domain_run.ram_run = domain_run.ram_run && !mstop_c_q[`LPMC_BIT_RAM_STOP];
        domain_run.dtc_run = domain_run.dtc_run && !mstop_a_q[`LPMC_BIT_DTC_STOP];
    end

    // Unit clocks need both the peripheral domain and a released
    // stop bit, so a stopped unit stays frozen across every mode
    always_comb begin
        unit_clk.mtu_clk_en = domain_run.periph_run && !mstop_a_q[`LPMC_BIT_MTU_STOP];
        unit_clk.can_clk_en = domain_run.periph_run && !mstop_b_q[`LPMC_BIT_CAN_STOP];
        unit_clk.elc_clk_en = domain_run.periph_run && !mstop_b_q[`LPMC_BIT_ELC_STOP];
        unit_clk.cmpb_clk_en = domain_run.periph_run && !mstop_b_q[`LPMC_BIT_CMPB_STOP];
    end

    // Retained-stop holds registers; no mode here reaches the powered-off stop
    assign units_retained = mode_q != lpmc_pkg::LPMC_RUN;
    assign units_power_off = 1'b0;

    // Register contents go out directly; consumers see a change
    // at the same edge where the write lands
    assign module_stop_a = mstop_a_q;
    assign module_stop_b = mstop_b_q;
    assign module_stop_c = mstop_c_q;
    assign module_stop_d = mstop_d_q;
    assign operating_power = op_power_q;
    assign return_clk_sel = ret_sel_q;
    assign return_clk_switch = ret_switch_q;
    assign sw_reset_req = sw_reset_q;
    assign clock_gen_wr_ok = protect_q[`LPMC_PROT_CLOCK_GEN];
    assign lp_timer_wr_ok = protect_q[`LPMC_PROT_LP_TIMER];
    assign volt_detect_wr_ok = protect_q[`LPMC_PROT_VOLT_DET];

endmodule

`default_nettype wire

/* File: lpmc_ctrl_props.sv */
`timescale 1ns/1ps
`default_nettype none
module lpmc_props (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Stimulus seen by the block
    input wire logic clk_en,
    input wire lpmc_pkg::lpmc_apb_req_type apb_req,
    input wire logic wait_exec,
    input wire logic wake_irq,
    // Block outputs
    input wire logic pslverr,
    input wire logic [31:0] module_stop_a,
    input wire logic [31:0] module_stop_c,
    input wire lpmc_pkg::lpmc_domain_type domain_run,
    input wire lpmc_pkg::lpmc_unit_clk_type unit_clk,
    input wire logic units_retained,
    input wire logic units_power_off,
    input wire logic clock_gen_wr_ok,
    input wire logic [2:0] return_clk_sel
);
    logic wr_q;
    logic [7:0] wr_addr_q;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Remembers the write that landed at the last edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_q <= 1'b0;
            wr_addr_q <= 8'h00;
        end else begin
            wr_q <= apb_req.psel && apb_req.penable && apb_req.pwrite && clk_en;
            wr_addr_q <= apb_req.paddr;
        end
    end
    sequence s_wait_taken;
        wait_exec && clk_en && !units_retained;
    endsequence
    sequence s_wake_taken;
        wake_irq && clk_en && units_retained;
    endsequence
    a_wait_enters_low: assert property (s_wait_taken |=> units_retained && !domain_run.cpu_run)
        else $error("wait did not enter a low power mode");
    a_wake_resumes_run: assert property (s_wake_taken |=> !units_retained ##0 domain_run.cpu_run)
        else $error("interrupt did not resume program");
    a_power_never_off: assert property (!units_power_off)
        else $error("unit reported powered off");
    a_retained_cpu_stop: assert property (units_retained |-> !domain_run.cpu_run)
        else $error("cpu runs while units retained");
    a_ram_stop_map: assert property (!units_retained |-> domain_run.ram_run == !module_stop_c[0])
        else $error("ram run differs from its stop bit");
    a_dtc_stop_map: assert property (!units_retained |-> domain_run.dtc_run == !module_stop_a[28])
        else $error("transfer controller run differs from stop bit");
    a_mtu_stop_map: assert property (!units_retained |-> unit_clk.mtu_clk_en == !module_stop_a[9])
        else $error("timer clock differs from its stop bit");
    a_stop_a_written: assert property ($changed(module_stop_a) |-> wr_q && wr_addr_q == 8'h04)
        else $error("stop register A changed without a write");
    a_ret_clk_written: assert property ($changed(return_clk_sel) |-> wr_q && wr_addr_q == 8'h18)
        else $error("return clock changed without a write");
    a_protect_written: assert property ($changed(clock_gen_wr_ok) |-> wr_q && wr_addr_q == 8'h24)
        else $error("protect bit changed without a write");
    a_unmapped_err: assert property (apb_req.psel && !apb_req.penable && clk_en
        && apb_req.paddr > 8'h28 |=> pslverr)
        else $error("unmapped access gave no error");
endmodule
bind lpmc_ctrl lpmc_props lpmc_props_inst (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
    .apb_req(apb_req), .wait_exec(wait_exec), .wake_irq(wake_irq), .pslverr(pslverr),
    .module_stop_a(module_stop_a), .module_stop_c(module_stop_c), .domain_run(domain_run),
    .unit_clk(unit_clk), .units_retained(units_retained), .units_power_off(units_power_off),
    .clock_gen_wr_ok(clock_gen_wr_ok), .return_clk_sel(return_clk_sel));
`default_nettype wire

/* File: tb_lpmc_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin \
    $display("mismatch t=%0t got=%h exp=%h", $time, (g), (e)); fail_count++; end end
module tb_lpmc_ctrl;
    logic pclk;
    logic presetn;
    logic clk_en;
    lpmc_pkg::lpmc_apb_req_type req;
    logic wait_exec, wake_irq, snz_req, snz_done;
    logic pready, pslverr, retained, power_off, ret_switch, sw_rst, cg_ok, lpt_ok, vd_ok;
    logic [31:0] prdata, stop_a, stop_b, stop_c, stop_d, r;
    lpmc_pkg::lpmc_domain_type dom;
    lpmc_pkg::lpmc_unit_clk_type uclk;
    logic [7:0] op_power;
    logic [2:0] ret_sel;
    logic err;
    int fail_count;
    int checked;
    lpmc_ctrl lpmc_ctrl_inst (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .apb_req(req),
        .pready(pready), .pslverr(pslverr), .prdata(prdata), .wait_exec(wait_exec),
        .wake_irq(wake_irq), .snooze_request(snz_req), .snooze_done(snz_done),
        .domain_run(dom), .unit_clk(uclk), .module_stop_a(stop_a), .module_stop_b(stop_b),
        .module_stop_c(stop_c), .module_stop_d(stop_d), .units_retained(retained),
        .units_power_off(power_off), .operating_power(op_power), .return_clk_sel(ret_sel),
        .return_clk_switch(ret_switch), .sw_reset_req(sw_rst), .clock_gen_wr_ok(cg_ok),
        .lp_timer_wr_ok(lpt_ok), .volt_detect_wr_ok(vd_ok));
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    task automatic print_verdict;
        $display("checked=%0d fail_count=%0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge pclk);
        req.psel <= 1'b1;
        req.pwrite <= wr;
        req.paddr <= a;
        req.pwdata <= wd;
        @(posedge pclk);
        req.penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        r = prdata;
        err = pslverr;
        if (n >= 50) fail_count++;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
        // Let the landing edge settle before callers look at outputs
        @(posedge pclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000);
        `CHK(r, e)
    endtask
    // Events are one-cycle pulses
    task automatic pulse(input int k);
        @(posedge pclk);
        case (k)
            0: wait_exec <= 1'b1;
            1: wake_irq <= 1'b1;
            2: snz_req <= 1'b1;
            default: snz_done <= 1'b1;
        endcase
        @(posedge pclk);
        wait_exec <= 1'b0;
        wake_irq <= 1'b0;
        snz_req <= 1'b0;
        snz_done <= 1'b0;
    endtask
    initial begin
        repeat (4000) @(posedge pclk);
        fail_count++;
        print_verdict;
    end
    initial begin
        req = '0;
        presetn = 1'b0;
        clk_en = 1'b1;
        {wait_exec, wake_irq, snz_req, snz_done} = 4'h0;
        fail_count = 0;
        checked = 0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        rc(8'h04, 32'hFFFF_FFFF);
        rc(8'h0C, 32'h7FFF_FFFE);
        wr(8'h04, 32'h0000_0000);
        rc(8'h04, 32'hFFFF_FFFF);
        wr(8'h24, 32'h0000_000F);
        `CHK(cg_ok, 1'b0)
        wr(8'h24, 32'h0000_A50F);
        `CHK({cg_ok, lpt_ok, vd_ok}, 3'b111)
        wr(8'h24, 32'h0000_A502);
        `CHK({cg_ok, lpt_ok, vd_ok}, 3'b000)
        wr(8'h04, 32'hEFFF_FDFF);
        `CHK({dom.dtc_run, uclk.mtu_clk_en}, 2'b11)
        wr(8'h08, 32'hFFFF_FAFE);
        `CHK({uclk.can_clk_en, uclk.elc_clk_en, uclk.cmpb_clk_en}, 3'b111)
        wr(8'h0C, 32'h7FFF_FFFF);
        `CHK(dom.ram_run, 1'b0)
        wr(8'h04, 32'hFFFF_FFFF);
        `CHK(uclk.mtu_clk_en, 1'b0)
        for (int c = 0; c < 3; c++) begin
            wr(8'h18, 32'h0000_0080 | 32'(c));
            rc(8'h18, 32'h0000_0080 | 32'(c));
            `CHK(ret_sel, 3'(c))
        end
        // Prohibited code with the enable set must leave the old code
        wr(8'h18, 32'h0000_0085);
        rc(8'h18, 32'h0000_0082);
        apb(1'b0, 8'h40, 32'h0000_0000);
        `CHK({err, r}, {1'b1, 32'h0000_0000})
        clk_en <= 1'b0;
        wr(8'h14, 32'h0000_005A);
        clk_en <= 1'b1;
        `CHK(op_power, 8'h00)
        wr(8'h14, 32'h0000_005A);
        `CHK(op_power, 8'h5A)
        for (int i = 0; i < 3; i++) begin
            wr(8'h00, {31'h0, i == 2});
            wr(8'h0C, {i == 1, 31'h0});
            pulse(0);
            rc(8'h28, 32'(i + 1));
            `CHK({retained, power_off}, 2'b10)
            pulse(1);
            rc(8'h28, 32'h0000_0000);
        end
        pulse(0);
        pulse(2);
        rc(8'h28, 32'h0000_0003);
        wr(8'h1C, 32'h0000_0080);
        pulse(2);
        rc(8'h28, 32'h0000_0004);
        `CHK({dom.cpu_run, dom.flash_run, dom.ram_run, dom.periph_run}, 4'b0011)
        pulse(3);
        rc(8'h28, 32'h0000_0003);
        pulse(2);
        pulse(1);
        rc(8'h28, 32'h0000_0000);
        print_verdict;
    end
endmodule
`default_nettype wire
